/* File: hdl/aiosc_core.sv */
// Analog I/O mode, scaling and relay block with an AXI4-Lite slave.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module aiosc_core
#(
  parameter int NRELAY = 4 // Relay outputs per group.
)
(
  // Clock and synchronous active-low reset.
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  // AXI4-Lite write address and data channels.
  input  wire logic [11:0]                            awaddr,
  input  wire logic [2:0]                             awprot,
  input  wire logic                                   awvalid,
  output logic                                        awready,
  input  wire logic [31:0]                            wdata,
  input  wire logic [3:0]                             wstrb,
  input  wire logic                                   wvalid,
  output logic                                        wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                                  bresp,
  output logic                                        bvalid,
  input  wire logic                                   bready,
  // AXI4-Lite read channels.
  input  wire logic [11:0]                            araddr,
  input  wire logic [2:0]                             arprot,
  input  wire logic                                   arvalid,
  output logic                                        arready,
  output logic [31:0]                                 rdata,
  output logic [1:0]                                  rresp,
  output logic                                        rvalid,
  input  wire logic                                   rready,
  // Converter results and calibration store, asynchronous pins.
  input  wire logic [aiosc_pkg::NGRP-1:0][15:0]       ain_pin,
  input  wire logic [aiosc_pkg::NGRP-1:0][3:0][15:0]  cal_pin,
  input  wire logic [15:0]                            vref_pin,
  input  wire logic [15:0]                            res_pin,
  // Converter front-end controls.
  output logic [aiosc_pkg::NGRP-1:0][2:0]             ain_mode,
  output logic [aiosc_pkg::NGRP-1:0][1:0]             aout_mode,
  output logic [aiosc_pkg::NGRP-1:0][11:0]            output_level_word,
  // Relay drives and their indicators.
  output logic [aiosc_pkg::NGRP-1:0][NRELAY-1:0]      relay_contact_output,
  output logic [aiosc_pkg::NGRP-1:0][NRELAY-1:0]      relay_indicator
);
  import aiosc_pkg::*;

  // Pin synchronisers; stage one is read only by stage two.
  logic [NGRP-1:0][15:0]      ain_s1, ain_s2;
  logic [NGRP-1:0][3:0][15:0] cal_s1, cal_s2;
  logic [15:0]                vref_s1, vref_s2;
  logic [15:0]                res_s1, res_s2;

  // Software-visible settings.
  logic [NGRP-1:0][NRELAY-1:0] relay_reg, relay_next;
  logic [NGRP-1:0][2:0]        input_type_select_reg, itype_next;
  logic [NGRP-1:0][1:0]        output_type_select_reg, otype_next;
  logic [NGRP-1:0][11:0]       oword_reg, oword_next;

  // Next values of the registered front-end outputs.
  logic [NGRP-1:0][2:0]        imode_next;
  logic [NGRP-1:0][1:0]        omode_next;
  logic [NGRP-1:0][11:0]       aword_next;

  // Bus slave state.
  logic        aw_hold_reg, aw_hold_next;
  logic        w_hold_reg, w_hold_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;

  logic        do_wr;  // Both write halves held, response free.
  logic        wr_ok;  // The held write names a writable register.
  logic        ar_hs;  // Read address taken this cycle.
  logic [15:0] wval;   // Write data merged over the current value.
  logic [11:0] wlim;   // Output word limit of the written group.

  // Address translation for the write and read paths.
  aiosc_map_if wmap();
  aiosc_map_if rmap();
  aiosc_unit_map u_wmap (.m (wmap));
  aiosc_unit_map u_rmap (.m (rmap));
  assign wmap.idx = awaddr_reg[11:2];
  assign rmap.idx = araddr[11:2];

  // Merges the two low byte lanes of a write over an old value.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = old;
    if (s[0])
      merge16[7:0] = d[7:0];
    if (s[1])
      merge16[15:8] = d[15:8];
  endfunction

  // Returns the visible value of a local register of one group.
  function automatic logic [15:0] reg_word(input logic [1:0] g,
                                           input logic [3:0] l);
    reg_word = 16'h0000;
    case (l)
      REG_RELAY: reg_word = 16'(relay_reg[g]);
      REG_ITYPE: reg_word = {13'h0000, input_type_select_reg[g]};
      REG_AIN:
        if (g == 2'h0)
          reg_word = {4'h0, ain_s2[g][ADC_W-1:0]};
        else if (ain_mode[g] != IM_OFF)
          reg_word = ain_s2[g];
      REG_OTYPE: reg_word = {14'h0000, output_type_select_reg[g]};
      REG_OWORD: reg_word = {4'h0, oword_reg[g]};
      REG_IN_GAIN, REG_IN_OFS, REG_OUT_GN, REG_OUT_OFS:
        reg_word = cal_s2[g][2'(l - REG_IN_GAIN)];
      REG_VREF: reg_word = vref_s2;
      REG_RES:
        if (g == 2'h0 && aout_mode[0] == OM_RES)
          reg_word = res_s2;
      default: reg_word = 16'h0000;
    endcase
  endfunction

  // Two-stage synchronisers for every pin input.
  always_ff @(posedge aclk)
  begin
    ain_s1  <= ain_pin;
    ain_s2  <= ain_s1;
    cal_s1  <= cal_pin;
    cal_s2  <= cal_s1;
    vref_s1 <= vref_pin;
    vref_s2 <= vref_s1;
    res_s1  <= res_pin;
    res_s2  <= res_s1;
  end

  // Handshake outputs; one write and one read are handled at a time.
  assign awready = !aw_hold_reg && !bvalid_reg;
  assign wready  = !w_hold_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign do_wr   = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign ar_hs   = arvalid && arready;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  // Only settings registers accept writes; the rest answer SLVERR.
  assign wr_ok = wmap.hit && (wmap.loc <= REG_OWORD)
                 && (wmap.loc != REG_AIN);
  assign wval  = merge16(reg_word(wmap.grp, wmap.loc), wdata_reg,
                         wstrb_reg);
  assign wlim  = (wmap.grp == 2'h0) ? AO_MAX_ONE : AO_MAX;

  // Next values of the bus slave channels.
  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    // Address and data are captured in either order.
    if (awvalid && awready)
    begin
      aw_hold_next = 1'b1;
      awaddr_next  = awaddr;
    end
    if (wvalid && wready)
    begin
      w_hold_next = 1'b1;
      wdata_next  = wdata;
      wstrb_next  = wstrb;
    end
    // The response follows once both halves are held.
    if (do_wr)
    begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_reg && bready)
      bvalid_next = 1'b0;
    // Read data is returned one cycle after the address.
    if (ar_hs)
    begin
      rvalid_next = 1'b1;
      rdata_next  = rmap.hit ? {16'h0000, reg_word(rmap.grp, rmap.loc)}
                             : 32'h00000000;
      rresp_next  = rmap.hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && rready)
      rvalid_next = 1'b0;
  end

  // Next values of the settings and of the front-end outputs.
  always_comb
  begin
    relay_next = relay_reg;
    itype_next = input_type_select_reg;
    otype_next = output_type_select_reg;
    oword_next = oword_reg;
    if (do_wr && wr_ok)
    begin
      case (wmap.loc)
        REG_RELAY: relay_next[wmap.grp] = wval[NRELAY-1:0];
        REG_ITYPE:
          // Group one holds a single type bit.
          if (wmap.grp == 2'h0)
            itype_next[wmap.grp] = {2'b00, wval[0]};
          else
            itype_next[wmap.grp] = wval[2:0];
        REG_OTYPE: otype_next[wmap.grp] = wval[1:0];
        REG_OWORD:
          // Words above the group's range are held at the limit.
          if (wval > {4'h0, wlim})
            oword_next[wmap.grp] = wlim;
          else
            oword_next[wmap.grp] = wval[11:0];
        default: ;
      endcase
    end
    for (int g = 0; g < NGRP; g++)
    begin
      // Input mode decode; unknown codes switch the input off.
      if (g == 0)
        imode_next[g] = input_type_select_reg[g][0] ? IM_MA20
                                                    : IM_V10;
      else if (input_type_select_reg[g] <= 3'(IM_R3W))
        imode_next[g] = input_type_select_reg[g];
      else
        imode_next[g] = IM_OFF;
      // Output mode decode; resistance exists only on group one.
      case (output_type_select_reg[g])
        2'h0: omode_next[g] = OM_V10;
        2'h1: omode_next[g] = OM_MA20;
        2'h3: omode_next[g] = (g == 0) ? OM_RES : OM_OFF;
        default: omode_next[g] = OM_OFF;
      endcase
      // An inactive or measuring output gets a zero level.
      if (omode_next[g] == OM_OFF || omode_next[g] == OM_RES)
        aword_next[g] = 12'h000;
      else
        aword_next[g] = oword_reg[g];
    end
  end

  // Registers every state group but the pin synchronisers; reset loads constants only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
      for (int g = 0; g < NGRP; g++)
      begin
        input_type_select_reg[g] <= (g == 0) ? RST_ITYPE_ONE
                                             : RST_ITYPE;
        output_type_select_reg[g] <= RST_OTYPE;
        oword_reg[g]              <= RST_OWORD;
        relay_reg[g]              <= '0;
        relay_contact_output[g]   <= '0;
        relay_indicator[g]        <= '0;
        ain_mode[g]               <= IM_V10;
        aout_mode[g]              <= OM_V10;
        output_level_word[g]      <= RST_OWORD;
      end
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      input_type_select_reg  <= itype_next;
      output_type_select_reg <= otype_next;
      oword_reg              <= oword_next;
      relay_reg              <= relay_next;
      relay_contact_output   <= relay_reg;
      relay_indicator        <= relay_reg;
      ain_mode               <= imode_next;
      aout_mode              <= omode_next;
      output_level_word      <= aword_next;
    end
  end

  // Checks on the block's outputs, settings and address map.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ONE_CURRENT: assert property (
    input_type_select_reg[0][0] |=> ain_mode[0] == IM_MA20)
    else $error("Group-one input not in current mode.");
  AST_MODE_MA: assert property (
    input_type_select_reg[1] == 3'h3 |=> ain_mode[1] == IM_MA20)
    else $error("Input code 3 did not select current.");
  AST_OFF_READS_ZERO: assert property (
    ar_hs && rmap.hit && rmap.grp != 2'h0 && rmap.loc == REG_AIN
    && ain_mode[rmap.grp] == IM_OFF |=> rdata_reg == 32'h00000000)
    else $error("Switched-off input read non-zero.");
  AST_RAW_WIDTH: assert property (
    ar_hs && rmap.hit && rmap.grp == 2'h0 && rmap.loc == REG_AIN
    |=> rvalid_reg && rdata_reg[31:12] == 20'h00000)
    else $error("Raw count wider than twelve bits.");
  AST_LEVEL_LIMIT: assert property (
    output_level_word[1] <= AO_MAX)
    else $error("Output word above 4000.");
  AST_RES_GATED: assert property (
    ar_hs && rmap.hit && rmap.grp == 2'h0 && rmap.loc == REG_RES
    && aout_mode[0] != OM_RES |=> rdata_reg == 32'h00000000)
    else $error("Resistance read outside resistance mode.");
  AST_UNIT_NATIVE: assert property (
    arvalid && araddr[11:10] == 2'h2 && araddr[9:2] == 8'h01
    |-> rmap.hit && rmap.grp == 2'h1 && rmap.loc == 4'h1)
    else $error("Unit 2 did not reach group two.");
  AST_UNIT_ZERO: assert property (
    arvalid && araddr[11:2] == 10'h065
    |-> rmap.hit && rmap.grp == 2'h1 && rmap.loc == 4'h1)
    else $error("Unit 0 number 101 not group two.");
  AST_RELAY_OPEN: assert property (
    relay_reg[0] == '0 |=> relay_contact_output[0] == '0)
    else $error("Relay closed with control bit off.");
  AST_RELAY_LED: assert property (
    relay_indicator == relay_contact_output)
    else $error("Relay indicator disagrees with relay.");
  AST_RESET_VOLT: assert property (
    $rose(aresetn) |-> input_type_select_reg[1] == RST_ITYPE
    ##1 ain_mode[1] == IM_V10)
    else $error("Input not in voltage mode after reset.");
  AST_UNDEF_OFF: assert property (
    output_type_select_reg[1][1] |=> aout_mode[1] == OM_OFF
    && output_level_word[1] == 12'h000)
    else $error("Undefined output code left channel active.");

  COV_WRITE: cover property (do_wr && wr_ok ##1 bvalid_reg);
  COV_READ: cover property (ar_hs ##1 rvalid_reg && rready);
  COV_RES_MODE: cover property (aout_mode[0] == OM_RES);
  COV_UNIT_ZERO: cover property (ar_hs && araddr[11:10] == 2'h0
                                 && rmap.grp == 2'h2);
endmodule

/* File: hdl/aiosc_pkg.sv */
// Constants and types shared by the analog I/O mode and scaling block.
package aiosc_pkg;
  localparam int NGRP  = 3;  // Number of I/O groups.
  localparam int VAL_W = 16; // Width of one register value.
  localparam int ADC_W = 12; // Width of the raw group-one count.
  localparam int NCAL  = 4;  // Correction words per group.
  localparam logic [7:0] NREG8      = 8'h0B; // Registers per group.
  localparam logic [7:0] UNIT0_STEP = 8'h64; // Unit-0 shift per group.
  localparam logic [7:0] UNIT0_TWO  = 8'hC8; // Twice the unit-0 shift.

  // Local register numbers inside one group.
  localparam logic [3:0] REG_RELAY   = 4'h0;
  localparam logic [3:0] REG_ITYPE   = 4'h1;
  localparam logic [3:0] REG_AIN     = 4'h2;
  localparam logic [3:0] REG_OTYPE   = 4'h3;
  localparam logic [3:0] REG_OWORD   = 4'h4;
  localparam logic [3:0] REG_IN_GAIN = 4'h5;
  localparam logic [3:0] REG_IN_OFS  = 4'h6;
  localparam logic [3:0] REG_OUT_GN  = 4'h7;
  localparam logic [3:0] REG_OUT_OFS = 4'h8;
  localparam logic [3:0] REG_VREF    = 4'h9;
  localparam logic [3:0] REG_RES     = 4'hA;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Output word limits for group one and for the other groups.
  localparam logic [11:0] AO_MAX_ONE = 12'hFFF;
  localparam logic [11:0] AO_MAX     = 12'hFA0;

  // Effective analog input modes.
  typedef enum logic [2:0] {
    IM_OFF  = 3'b000,
    IM_V10  = 3'b001,
    IM_V2P5 = 3'b010,
    IM_MA20 = 3'b011,
    IM_R2W  = 3'b100,
    IM_R3W  = 3'b101
  } aiosc_imode_e;

  // Effective analog output modes; code 2 is the safe inactive state.
  typedef enum logic [1:0] {
    OM_V10  = 2'b00,
    OM_MA20 = 2'b01,
    OM_OFF  = 2'b10,
    OM_RES  = 2'b11
  } aiosc_omode_e;

  // Values after reset: inputs measure voltage, outputs drive 0 V.
  localparam logic [2:0]  RST_ITYPE_ONE = 3'h0;
  localparam logic [2:0]  RST_ITYPE     = 3'h1;
  localparam logic [1:0]  RST_OTYPE     = 2'h0;
  localparam logic [11:0] RST_OWORD     = 12'h000;
endpackage

/* File: hdl/aiosc_map_if.sv */
// Interface that carries one register address through the unit map.
`timescale 1ns/10ps
interface aiosc_map_if;
  logic [9:0] idx; // Word index: unit in the top two bits, number below.
  logic [1:0] grp; // Selected group, zero based.
  logic [3:0] loc; // Local register number inside the group.
  logic       hit; // High when the address names a register.
  modport req (output idx, input grp, input loc, input hit);
  modport map (input idx, output grp, output loc, output hit);
endinterface

/* File: hdl/aiosc_unit_map.sv */
// Unit address and register number translation for the I/O groups.
`timescale 1ns/10ps
module aiosc_unit_map
(
  // Address to translate and its result.
  aiosc_map_if.map m
);
  import aiosc_pkg::*;

  logic [1:0] unit;  // Protocol unit address.
  logic [7:0] num;   // Register number as seen at that unit.
  logic [7:0] loc8;  // Register number inside the selected group.

  // Unit N reaches group N directly; unit 0 shifts each group by 100.
  always_comb
  begin
    unit  = m.idx[9:8];
    num   = m.idx[7:0];
    m.grp = 2'h0;
    loc8  = num;
    if (unit == 2'h0)
    begin
      // Combined unit: the hundreds select the group.
      if (num >= UNIT0_TWO)
      begin
        m.grp = 2'h2;
        loc8  = num - UNIT0_TWO;
      end
      else if (num >= UNIT0_STEP)
      begin
        m.grp = 2'h1;
        loc8  = num - UNIT0_STEP;
      end
    end
    else
    begin
      // Unit equal to the group number uses native numbers.
      m.grp = unit - 2'h1;
    end
    m.loc = loc8[3:0];
    m.hit = (loc8 < NREG8) && (m.grp < 2'(NGRP));
  end
endmodule

/* File: verification/aiosc_host.sv */
// Host model that reaches the block's registers over AXI4-Lite.
`timescale 1ns/10ps
module aiosc_host
(
  // Clock of the register bus.
  input  wire logic        aclk,
  // Write address, data and response channels.
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read address and data channels.
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int stuck = 0; // Waits that ran out of cycles.

  // Every request line starts idle at time zero.
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Unit in the top bits, register number below, word aligned.
  function automatic logic [11:0] adr(input logic [1:0] u,
                                      input logic [7:0] n);
    return {u, n, 2'h0};
  endfunction

  // One write; both halves offered together, then the response.
  task automatic write(input logic [1:0] u, input logic [7:0] n,
                       input logic [31:0] d, output logic [1:0] r);
    int  i;
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    r = 2'h3;
    awaddr  <= adr(u, n);
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (i = 0; i < 64 && !(a && w); i++)
    begin
      @(posedge aclk);
      if (!a && awready)
      begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    for (i = 0; i < 64 && r === 2'h3; i++)
    begin
      @(posedge aclk);
      if (bvalid)
        r = bresp;
    end
    bready <= 1'b0;
    if (!(a && w) || r === 2'h3)
      stuck++;
  endtask

  // One read; address first, then the data beat.
  task automatic read(input logic [1:0] u, input logic [7:0] n,
                      output logic [31:0] d, output logic [1:0] r);
    int   i;
    logic got;
    got = 1'b0;
    araddr  <= adr(u, n);
    arvalid <= 1'b1;
    for (i = 0; i < 64 && !got; i++)
    begin
      @(posedge aclk);
      got = arready;
    end
    arvalid <= 1'b0;
    rready  <= 1'b1;
    got = 1'b0;
    for (i = 0; i < 64 && !got; i++)
    begin
      @(posedge aclk);
      got = rvalid;
      d   = rdata;
      r   = rresp;
    end
    rready <= 1'b0;
    if (!got)
      stuck++;
  endtask
endmodule

/* File: verification/analog_io_mode_and_scaling_bench.sv */
// Self-checking bench for the analog I/O mode and scaling block.
`timescale 1ns/10ps
module analog_io_mode_and_scaling_bench;
  import aiosc_pkg::*;
  logic                       aclk = 1'b0;    // Bus clock, 40 MHz.
  logic                       aresetn = 1'b0; // Reset, active low.
  logic [11:0]                awaddr, araddr; // Bus addresses.
  logic [31:0]                wdata, rdata;   // Bus data.
  logic [1:0]                 bresp, rresp;   // Response codes.
  logic                       awvalid, awready, wvalid, wready;
  logic                       bvalid, bready, arvalid, arready;
  logic                       rvalid, rready;
  logic [NGRP-1:0][15:0]      ain_pin;        // Converter results.
  logic [NGRP-1:0][3:0][15:0] cal_pin;        // Correction words.
  logic [15:0]                vref_pin, res_pin;
  logic [NGRP-1:0][2:0]       ain_mode;
  logic [NGRP-1:0][1:0]       aout_mode;
  logic [NGRP-1:0][11:0]      output_level_word;
  logic [NGRP-1:0][3:0]       relay_contact_output, relay_indicator;
  int                         mismatches = 0; // Failed comparisons.
  int                         checks = 0;     // All comparisons.

  // Clock toggles each half period.
  always #12.5 aclk = ~aclk;

  aiosc_core u_aiosc_core (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ain_pin(ain_pin),
    .cal_pin(cal_pin), .vref_pin(vref_pin), .res_pin(res_pin),
    .ain_mode(ain_mode), .aout_mode(aout_mode),
    .output_level_word(output_level_word),
    .relay_contact_output(relay_contact_output),
    .relay_indicator(relay_indicator));

  aiosc_host u_aiosc_host (.aclk(aclk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    mismatches += u_aiosc_host.stuck;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compares one value and reports a difference at once.
  task automatic chk(input string nm, input logic [31:0] e, s);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Bus write with its expected response; a hang ends the run.
  task automatic wr(input logic [1:0] u, input logic [7:0] n,
                    input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_aiosc_host.write(u, n, d, r);
    if (u_aiosc_host.stuck != 0)
      close_out();
    chk("bresp", 32'(er), 32'(r));
  endtask

  // Bus read with its expected data and response.
  task automatic rd(input logic [1:0] u, input logic [7:0] n,
                    input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    u_aiosc_host.read(u, n, d, r);
    if (u_aiosc_host.stuck != 0)
      close_out();
    chk("rdata", ed, d);
    chk("rresp", 32'(er), 32'(r));
  endtask

  // Lets a written setting reach the outputs.
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask

  // Outputs straight after reset.
  task automatic t_reset();
    for (int g = 0; g < NGRP; g++)
    begin
      chk("ain_mode", 32'h1, 32'(ain_mode[g]));
      chk("aout_mode", 32'h0, 32'(aout_mode[g]));
      chk("relay", 32'h0, 32'(relay_contact_output[g]));
    end
  endtask

  // Input type codes of group one and of group two.
  task automatic t_inputs();
    wr(2'h1, 8'h01, 32'h1, RESP_OKAY);
    settle();
    chk("ain_mode one", 32'h3, 32'(ain_mode[0]));
    wr(2'h1, 8'h01, 32'h0, RESP_OKAY);
    settle();
    chk("ain_mode one", 32'h1, 32'(ain_mode[0]));
    for (int c = 0; c < 7; c++)
    begin
      wr(2'h2, 8'h01, 32'(c), RESP_OKAY);
      settle();
      chk("ain_mode", 32'(c % 6), 32'(ain_mode[1]));
    end
    rd(2'h2, 8'h02, 32'h0, RESP_OKAY);
  endtask

  // Output type codes, undefined codes and output words.
  task automatic t_outputs();
    logic [1:0] code [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    foreach (code[i])
    begin
      wr(2'h1, 8'h03, 32'(code[i]), RESP_OKAY);
      settle();
      chk("aout_mode", 32'(code[i]), 32'(aout_mode[0]));
    end
    wr(2'h2, 8'h03, 32'h3, RESP_OKAY);
    wr(2'h2, 8'h04, 32'h898, RESP_OKAY);
    settle();
    chk("aout_mode", 32'h2, 32'(aout_mode[1]));
    chk("level", 32'h0, 32'(output_level_word[1]));
    wr(2'h2, 8'h03, 32'h0, RESP_OKAY);
    settle();
    chk("level", 32'h898, 32'(output_level_word[1]));
    wr(2'h2, 8'h04, 32'hFA1, RESP_OKAY);
    settle();
    chk("level", 32'hFA0, 32'(output_level_word[1]));
    wr(2'h1, 8'h03, 32'h0, RESP_OKAY);
    wr(2'h1, 8'h04, 32'hFFF, RESP_OKAY);
    settle();
    chk("level one", 32'hFFF, 32'(output_level_word[0]));
  endtask

  // Values, corrections, reference and resistance read back.
  task automatic t_values();
    wr(2'h2, 8'h01, 32'h1, RESP_OKAY);
    settle();
    rd(2'h2, 8'h01, 32'h1, RESP_OKAY);
    rd(2'h1, 8'h02, 32'(ain_pin[0][11:0]), RESP_OKAY);
    rd(2'h2, 8'h02, 32'(ain_pin[1]), RESP_OKAY);
    for (int g = 0; g < NGRP; g++)
      for (int k = 0; k < NCAL; k++)
        rd(2'(g + 1), 8'(5 + k), 32'(cal_pin[g][k]), RESP_OKAY);
    rd(2'h1, 8'h09, 32'(vref_pin), RESP_OKAY);
    rd(2'h1, 8'h0A, 32'h0, RESP_OKAY);
    wr(2'h1, 8'h03, 32'h3, RESP_OKAY);
    settle();
    rd(2'h1, 8'h0A, 32'(res_pin), RESP_OKAY);
  endtask

  // Native units and the shifted numbers of unit zero.
  task automatic t_units();
    wr(2'h0, 8'h65, 32'h4, RESP_OKAY);
    wr(2'h0, 8'hC9, 32'h5, RESP_OKAY);
    settle();
    chk("ain_mode two", 32'h4, 32'(ain_mode[1]));
    chk("ain_mode three", 32'h5, 32'(ain_mode[2]));
    rd(2'h0, 8'h65, 32'h4, RESP_OKAY);
    wr(2'h3, 8'h01, 32'h3, RESP_OKAY);
    wr(2'h0, 8'hC8, 32'hA, RESP_OKAY);
    wr(2'h1, 8'h00, 32'h5, RESP_OKAY);
    settle();
    chk("ain_mode three", 32'h3, 32'(ain_mode[2]));
    chk("relay three", 32'hA, 32'(relay_contact_output[2]));
    chk("lamp three", 32'hA, 32'(relay_indicator[2]));
    chk("relay one", 32'h5, 32'(relay_contact_output[0]));
    chk("lamp one", 32'h5, 32'(relay_indicator[0]));
    wr(2'h1, 8'h00, 32'h0, RESP_OKAY);
    settle();
    chk("relay one", 32'h0, 32'(relay_contact_output[0]));
    chk("lamp one", 32'h0, 32'(relay_indicator[0]));
  endtask

  // Unmapped number and read-only places are refused.
  task automatic t_errors();
    rd(2'h1, 8'h0B, 32'h0, RESP_SLVERR);
    wr(2'h1, 8'h05, 32'h7, RESP_SLVERR);
    rd(2'h1, 8'h05, 32'(cal_pin[0][0]), RESP_OKAY);
  endtask

  // Pins at time zero, reset, then every scenario in turn.
  initial
  begin
    ain_pin  = {16'h0123, 16'h0456, 16'h0BCD};
    vref_pin = 16'h0CE4;
    res_pin  = 16'h03E8;
    for (int g = 0; g < NGRP; g++)
      for (int k = 0; k < NCAL; k++)
        cal_pin[g][k] = 16'(16'h1100 + 16'h10 * g + k);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    t_reset();
    t_inputs();
    t_outputs();
    t_values();
    t_units();
    t_errors();
    close_out();
  end
endmodule
